// file: core/sism_consts.svh
`ifndef SISM_CONSTS_SVH
`define SISM_CONSTS_SVH
// Register byte addresses
`define SISM_ADDR_STATUS_MASK 12'h000
`define SISM_ADDR_SOURCE_CTRL 12'h004
`define SISM_ADDR_RAW_EVENTS 12'h008
// Status field positions
`define SISM_BIT_AGE 0
`define SISM_BIT_LEARN 1
`define SISM_BIT_FAULT 2
`define SISM_BIT_DRAIN 3
`define SISM_BIT_PAUSE_ON 4
`define SISM_BIT_PAUSE_OFF 5
`define SISM_BIT_LINK 6
`define SISM_BIT_TIMER 12
`define SISM_BIT_MGMT 13
`define SISM_BIT_PIN 14
`define SISM_MASK_SHIFT 16
// Writable status positions and mask positions
`define SISM_STATUS_BITS 32'h0000_707f
`define SISM_MASK_BITS 32'h707f_0000
// Reserved fields read back as their reset values
`define SISM_RESERVED_ONES 32'h8f80_0000
// Reset values
`define SISM_RST_STATUS 16'h0000
`define SISM_RST_MASK 16'hffff
`define SISM_RST_CTRL 3'h0
// Source control bit positions
`define SISM_CTRL_POLL 0
`define SISM_CTRL_REVMII 1
`define SISM_CTRL_SLAVE 2
`endif

// file: core/sism_pkg.sv
package sism_pkg;
  typedef logic [31:0] sism_word_t;
  typedef logic [11:0] sism_addr_t;
  typedef logic [15:0] sism_half_t;
  typedef logic [2:0] sism_link_t;
endpackage : sism_pkg

// file: core/sism_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sism_edge_sync (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Raw event level
  input wire logic i_raw,
  // Synchronised level and rising pulse
  output logic o_level,
  output logic o_rise
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb begin
    next_meta = i_raw;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign o_level = sync;
  assign o_rise = sync & ~prev;
endmodule : sism_edge_sync
`default_nettype wire

// file: core/sism_top.sv
// Notes on behaviour
// - Table age-out sets status bit 0
// - New source learn sets status bit 1
// - Host ingress error sets status bit 2
// - Host egress FIFO empty sets bit 3
// - Host ingress pause start sets bit 4
// - Host ingress pause end sets bit 5
// - Link change sets bit 6 when polling
// - Timer limit sets status bit 12
// - Slave management write sets bit 13 if enabled
// - Pin event sets status bit 14
// - Status sticky, write one clears, zero keeps
// - Mask bit one keeps source off pin
// - Reset: status zero, masks all one
`timescale 1ns/1ps
`default_nettype none
`include "sism_consts.svh"
module sism_top (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire sism_pkg::sism_addr_t i_paddr,
  input wire sism_pkg::sism_word_t i_pwdata,
  output sism_pkg::sism_word_t o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Event sources, levels from outside the clock domain
  input wire logic i_table_age_expire,
  input wire logic i_table_source_added,
  input wire logic i_host_ingress_fault,
  input wire logic i_host_egress_drained,
  input wire logic i_host_ingress_pause,
  input wire sism_pkg::sism_link_t i_port_link_up,
  input wire logic i_general_timer_expire,
  input wire logic i_mgmt_slave_write,
  input wire logic i_pin_event,
  // Interrupt pin
  output logic o_irq
);
  import sism_pkg::*;

  localparam int NSRC = 10;
  localparam int NRAW = 11;

  // Raw level order feeding the synchronisers
  logic [NRAW-1:0] raw_in;
  logic [NRAW-1:0] raw_lvl;
  logic [NRAW-1:0] raw_rise;
  logic [NRAW-1:0] raw_fall;
  logic [NRAW-1:0] raw_prev;

  assign raw_in = {i_port_link_up, i_pin_event, i_mgmt_slave_write, i_general_timer_expire,
                   i_host_ingress_pause, i_host_egress_drained, i_host_ingress_fault,
                   i_table_source_added, i_table_age_expire};

  genvar gi;
  generate
    for (gi = 0; gi < NRAW; gi++) begin : g_sync
      sism_edge_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_raw(raw_in[gi]),
        .o_level(raw_lvl[gi]),
        .o_rise(raw_rise[gi])
      );
    end
  endgenerate

  // Level history for falling edges (pause end, link down)
  logic [NRAW-1:0] next_raw_prev;
  always_comb begin
    next_raw_prev = raw_lvl;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      raw_prev <= '0;
    end else begin
      raw_prev <= next_raw_prev;
    end
  end
  assign raw_fall = raw_prev & ~raw_lvl;

  // Registers
  sism_half_t status;
  sism_half_t mask;
  logic [2:0] ctrl;
  sism_word_t prdata;
  logic pready;
  logic pslverr;
  logic irq;
  sism_half_t next_status;
  sism_half_t next_mask;
  logic [2:0] next_ctrl;
  sism_word_t next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;

  // Event pulses per status position
  sism_half_t set_ev;
  sism_half_t clr_ev;
  logic wr_acc;
  logic rd_acc;
  logic hit_sm;
  logic hit_ctrl;
  logic hit_raw;
  logic link_chg;

  always_comb begin
    wr_acc = i_psel & i_penable & i_pwrite & pready;
    rd_acc = i_psel & ~i_penable & ~i_pwrite;
    hit_sm = (i_paddr == `SISM_ADDR_STATUS_MASK);
    hit_ctrl = (i_paddr == `SISM_ADDR_SOURCE_CTRL);
    hit_raw = (i_paddr == `SISM_ADDR_RAW_EVENTS);
    link_chg = |(raw_rise[NRAW-1:NRAW-3] | raw_fall[NRAW-1:NRAW-3]);
    set_ev = '0;
    set_ev[`SISM_BIT_AGE] = raw_rise[0];
    set_ev[`SISM_BIT_LEARN] = raw_rise[1];
    set_ev[`SISM_BIT_FAULT] = raw_rise[2];
    set_ev[`SISM_BIT_DRAIN] = raw_rise[3];
    set_ev[`SISM_BIT_PAUSE_ON] = raw_rise[4];
    set_ev[`SISM_BIT_PAUSE_OFF] = raw_fall[4];
    set_ev[`SISM_BIT_LINK] = link_chg & ctrl[`SISM_CTRL_POLL];
    set_ev[`SISM_BIT_TIMER] = raw_rise[5];
    set_ev[`SISM_BIT_MGMT] = raw_rise[6] & ctrl[`SISM_CTRL_REVMII] & ctrl[`SISM_CTRL_SLAVE];
    set_ev[`SISM_BIT_PIN] = raw_rise[7];
    clr_ev = '0;
    if (wr_acc && hit_sm) begin
      clr_ev = i_pwdata[15:0] & 16'(`SISM_STATUS_BITS);
    end
  end

  always_comb begin
    next_status = (status & ~clr_ev) | set_ev;
    next_mask = mask;
    next_ctrl = ctrl;
    if (wr_acc && hit_sm) begin
      next_mask = (i_pwdata[31:16] & 16'(`SISM_MASK_BITS >> `SISM_MASK_SHIFT))
                  | 16'(`SISM_RESERVED_ONES >> `SISM_MASK_SHIFT);
    end
    if (wr_acc && hit_ctrl) begin
      next_ctrl = i_pwdata[2:0];
    end
    next_pready = i_psel & i_penable & ~pready;
    next_pslverr = i_psel & i_penable & ~pready & ~(hit_sm | hit_ctrl | hit_raw);
    next_prdata = prdata;
    if (rd_acc) begin
      next_prdata = 32'h0000_0000;
      if (hit_sm) begin
        next_prdata = {mask, status};
      end else if (hit_ctrl) begin
        next_prdata = {29'h0000_0000, ctrl};
      end else if (hit_raw) begin
        next_prdata = {21'h00_0000, raw_lvl};
      end
    end
    next_irq = |(next_status & ~next_mask);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      status <= `SISM_RST_STATUS;
      mask <= `SISM_RST_MASK;
      ctrl <= `SISM_RST_CTRL;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  assign o_prdata = prdata;
  assign o_pready = pready;
  assign o_pslverr = pslverr;
  assign o_irq = irq;

  // Checks
  logic sm_write_seen;
  assign sm_write_seen = i_psel & i_penable & i_pwrite & pready & (i_paddr == `SISM_ADDR_STATUS_MASK);
  sequence s_age_clear;
    sm_write_seen && i_pwdata[`SISM_BIT_AGE] && !raw_rise[0];
  endsequence
  sequence s_apb_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_apb_access;
    i_psel && i_penable && !pready;
  endsequence

  a_age_sets: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    raw_rise[0] |=> status[`SISM_BIT_AGE])
    else $error("age event did not set flag");
  a_learn_sets: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    raw_rise[1] |=> status[`SISM_BIT_LEARN])
    else $error("learn event did not set flag");
  a_fault_sets: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    raw_rise[2] |=> status[`SISM_BIT_FAULT])
    else $error("fault event did not set flag");
  a_drain_sets: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    raw_rise[3] |=> status[`SISM_BIT_DRAIN])
    else $error("drain event did not set flag");
  a_pause_on: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(raw_lvl[4]) |=> status[`SISM_BIT_PAUSE_ON])
    else $error("pause start did not set flag");
  a_pause_off: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $fell(raw_lvl[4]) |=> status[`SISM_BIT_PAUSE_OFF])
    else $error("pause end did not set flag");
  a_link_gated: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !status[`SISM_BIT_LINK] && !ctrl[`SISM_CTRL_POLL] |=> !status[`SISM_BIT_LINK])
    else $error("link flag set with polling off");
  a_timer_sets: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    raw_rise[5] |=> status[`SISM_BIT_TIMER])
    else $error("timer event did not set flag");
  a_mgmt_gated: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    raw_rise[6] && ctrl[1] && ctrl[2] |=> status[`SISM_BIT_MGMT])
    else $error("management write did not set flag");
  a_pin_sets: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    raw_rise[7] |=> status[`SISM_BIT_PIN])
    else $error("pin event did not set flag");
  a_sticky_clear: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_age_clear |=> !status[`SISM_BIT_AGE])
    else $error("write one did not clear flag");
  a_sticky_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    status[`SISM_BIT_AGE] && !(sm_write_seen && i_pwdata[`SISM_BIT_AGE]) |=> status[`SISM_BIT_AGE])
    else $error("flag lost without clear");
  a_mask_block: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (status & ~mask) == 16'h0000 |-> !irq)
    else $error("masked source drove pin");
  a_reset_vals: assert property (@(posedge i_sys_clk)
    $past(i_srst) && !i_srst |-> status == `SISM_RST_STATUS && mask == `SISM_RST_MASK && !irq && !pready)
    else $error("wrong reset values");
  a_pin_follows: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    1'b1 |=> irq == |(status & ~mask))
    else $error("pin does not match pending sources");

  a_link_sets: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    link_chg && ctrl[`SISM_CTRL_POLL] |=> status[`SISM_BIT_LINK])
    else $error("link change did not set flag");
  a_mgmt_blocked: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !status[`SISM_BIT_MGMT] && !(ctrl[`SISM_CTRL_REVMII] && ctrl[`SISM_CTRL_SLAVE]) |=> !status[`SISM_BIT_MGMT])
    else $error("management flag set while disabled");
  a_age_quiet: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !status[`SISM_BIT_AGE] && !raw_rise[0] |=> !status[`SISM_BIT_AGE])
    else $error("age flag set without event");
  a_pause_quiet: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !status[`SISM_BIT_PAUSE_OFF] && !raw_fall[4] |=> !status[`SISM_BIT_PAUSE_OFF])
    else $error("pause end flag set without event");
  a_timer_quiet: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !status[`SISM_BIT_TIMER] && !raw_rise[5] |=> !status[`SISM_BIT_TIMER])
    else $error("timer flag set without event");
  a_pin_quiet: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !status[`SISM_BIT_PIN] && !raw_rise[7] |=> !status[`SISM_BIT_PIN])
    else $error("pin event flag set without event");
  a_status_resvd: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (status & ~16'(`SISM_STATUS_BITS)) == 16'h0000)
    else $error("reserved status bit set");
  a_mask_resvd: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (mask & 16'(`SISM_RESERVED_ONES >> `SISM_MASK_SHIFT)) == 16'(`SISM_RESERVED_ONES >> `SISM_MASK_SHIFT))
    else $error("reserved mask bit cleared");
  a_all_masked: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    mask == 16'hffff |-> !irq)
    else $error("pin high with every source masked");
  a_mask_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !sm_write_seen |=> $stable(mask))
    else $error("mask changed without write");
  a_ctrl_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !(i_psel && i_penable && i_pwrite && pready && hit_ctrl) |=> $stable(ctrl))
    else $error("control changed without write");
  a_apb_ready: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_apb_setup ##1 s_apb_access |=> pready)
    else $error("bus access not answered");
  a_ready_pulse: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    pslverr |-> pready)
    else $error("error without ready");

  // Per-source pin and sticky checks
  localparam int SPOS [NSRC] = '{`SISM_BIT_AGE, `SISM_BIT_LEARN, `SISM_BIT_FAULT, `SISM_BIT_DRAIN,
                                 `SISM_BIT_PAUSE_ON, `SISM_BIT_PAUSE_OFF, `SISM_BIT_LINK,
                                 `SISM_BIT_TIMER, `SISM_BIT_MGMT, `SISM_BIT_PIN};
  genvar gs;
  generate
    for (gs = 0; gs < NSRC; gs++) begin : g_src_chk
      a_src_drives: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        status[SPOS[gs]] && !mask[SPOS[gs]] |-> irq)
        else $error("unmasked source did not drive pin");
      a_src_sticky: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        status[SPOS[gs]] && !(sm_write_seen && i_pwdata[SPOS[gs]]) |=> status[SPOS[gs]])
        else $error("flag lost without clear");
    end
  endgenerate
endmodule : sism_top
`default_nettype wire

// file: tb/sism_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module sism_src_model (
  // Clock
  input wire logic i_sys_clk,
  // Toggle requests
  input wire logic [10:0] i_kick,
  // Event levels
  output logic [10:0] o_lvl
);
  logic [10:0] lvl_q = 11'h000;
  always @(posedge i_sys_clk) begin
    lvl_q <= lvl_q ^ i_kick;
  end
  assign o_lvl = lvl_q;
endmodule : sism_src_model
`default_nettype wire

// file: tb/tb_sism_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sism_top;
  import sism_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  sism_addr_t i_paddr = 12'h000;
  sism_word_t i_pwdata = 32'h0000_0000;
  sism_word_t o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic o_irq;
  logic [10:0] kick = 11'h000;
  logic [10:0] lvl;
  int fails = 0;
  int n_checks = 0;
  logic [32:0] exp_q[$];
  logic [32:0] e_m;
  sism_word_t st;
  sism_word_t w;
  int n;
  int kix[10] = '{0, 1, 2, 3, 4, 4, 5, 8, 9, 10};
  int sbit[10] = '{0, 1, 2, 3, 4, 5, 6, 12, 13, 14};
  always #50 i_sys_clk = ~i_sys_clk;
  sism_src_model sism_src_model_inst (.i_sys_clk(i_sys_clk), .i_kick(kick), .o_lvl(lvl));
  sism_top sism_top_inst (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_table_age_expire(lvl[0]),
    .i_table_source_added(lvl[1]), .i_host_ingress_fault(lvl[2]), .i_host_egress_drained(lvl[3]),
    .i_host_ingress_pause(lvl[4]), .i_port_link_up(lvl[7:5]), .i_general_timer_expire(lvl[8]),
    .i_mgmt_slave_write(lvl[9]), .i_pin_event(lvl[10]), .o_irq(o_irq));
  task automatic test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int c);
    repeat (c) @(posedge i_sys_clk);
  endtask : tick
  task automatic apb(input logic wr, input sism_addr_t a, input sism_word_t d, input logic [32:0] e);
    int k;
    exp_q.push_back(e);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      test_done();
    end
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask : apb
  always @(posedge i_sys_clk) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      e_m = exp_q.pop_front();
      cmp({o_pslverr, i_pwrite ? e_m[31:0] : o_prdata}, e_m);
    end
  end
  initial begin
    void'($urandom(32'h6194));
    repeat (3) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    @(posedge i_sys_clk);
    st = 32'hffff_0000;
    apb(1'b0, 12'h000, 32'h0, {1'b0, st});
    apb(1'b1, 12'h004, 32'h7, 33'h0);
    apb(1'b0, 12'h004, 32'h0, 33'h7);
    for (int i = 0; i < 10; i++) begin
      kick <= 11'h001 << kix[i];
      tick(1);
      kick <= 11'h000;
      tick(6);
      st[sbit[i]] = 1'b1;
      apb(1'b0, 12'h000, 32'h0, {1'b0, st});
    end
    cmp({32'h0, o_irq}, 33'h0);
    apb(1'b1, 12'h000, 32'hffff_0000, 33'h0);
    apb(1'b0, 12'h000, 32'h0, {1'b0, st});
    n = $urandom_range(9, 0);
    st[sbit[n] + 16] = 1'b0;
    apb(1'b1, 12'h000, {st[31:16], 16'h0}, 33'h0);
    tick(3);
    cmp({32'h0, o_irq}, 33'h1);
    w = {st[31:16], 16'h0} | (32'h1 << sbit[n]);
    st[sbit[n]] = 1'b0;
    apb(1'b1, 12'h000, w, 33'h0);
    tick(3);
    cmp({32'h0, o_irq}, 33'h0);
    apb(1'b1, 12'h004, 32'h0, 33'h0);
    kick <= 11'h200;
    tick(1);
    kick <= 11'h000;
    tick(6);
    st[6] = 1'b0;
    st[13] = 1'b0;
    apb(1'b1, 12'h000, {st[31:16], 16'h2040}, 33'h0);
    kick <= 11'h240;
    tick(1);
    kick <= 11'h000;
    tick(6);
    apb(1'b0, 12'h000, 32'h0, {1'b0, st});
    apb(1'b1, 12'h00c, 32'hffff_ffff, {1'b1, 32'h0});
    apb(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0});
    apb(1'b0, 12'h000, 32'h0, {1'b0, st});
    apb(1'b0, 12'h008, 32'h0, {22'h0, lvl[7:5], lvl[10:8], lvl[4:0]});
    st[15:0] = 16'h0000;
    apb(1'b1, 12'h000, {st[31:16], 16'h707f}, 33'h0);
    apb(1'b0, 12'h000, 32'h0, {1'b0, st});
    cmp({32'h0, o_irq}, 33'h0);
    test_done();
  end
endmodule : tb_sism_top
`default_nettype wire
